// ==== hdl/link_map.svh ====
`ifndef LINK_MAP_SVH
`define LINK_MAP_SVH
`define CLOCK_PERIOD_NS 8
`define WRITE_TIME_NS 5000000
`define WRITE_CYCLES (`WRITE_TIME_NS / `CLOCK_PERIOD_NS)
`define BIT_TIME_NS 2500
`define QUARTER_CYCLES (`BIT_TIME_NS / 4 / `CLOCK_PERIOD_NS)
`define ADDR_WIDTH 13
`define SECTOR_COUNT 64
`define PAGE_BYTES 4
`define TYPE_ID 4'hA
`define CE_LOW_BITS 2'h3
`define DIR_READ 1'h1
`endif

// ==== hdl/link_pkg.sv ====
package link_pkg;
	typedef enum logic [2:0] {
		st_idle = 3'h0,
		st_sel = 3'h1,
		st_ahi = 3'h2,
		st_alo = 3'h3,
		st_wdata = 3'h4,
		st_rdata = 3'h5
	} slave_state_type;
	typedef enum logic [1:0] {
		m_idle = 2'h0,
		m_start = 2'h1,
		m_bits = 2'h2,
		m_stop = 2'h3
	} master_state_type;
	typedef enum logic [1:0] {
		op_start = 2'h0,
		op_write = 2'h1,
		op_read = 2'h2,
		op_stop = 2'h3
	} op_type;
endpackage

// ==== hdl/i2c_link_if.sv ====
`timescale 1ns/1ps
interface i2c_link_if;
	logic scl;
	logic master_sda_o;
	logic master_sda_oe;
	logic device_sda_o;
	logic device_sda_oe;
	logic sda;
	// Open-drain wired-AND of both ends
	assign sda = ~((master_sda_oe & ~master_sda_o) | (device_sda_oe & ~device_sda_o));
	modport master (output scl, output master_sda_o, output master_sda_oe, input sda);
	modport device (input scl, output device_sda_o, output device_sda_oe, input sda);
endinterface

// ==== hdl/tag_slave_end.sv ====
// Summary of operation
// R01 - Select byte MSB first, type 1010
// R02 - Eighth select bit: 1 read, 0 write
// R03 - Ack matching select, else release, standby
// R04 - Write: ack two address bytes, then data
// R05 - Master sends address high byte first
// R06 - Locked without password: no store, nack
// R07 - Write cycle only on tenth-slot Stop
// R08 - After write, counter follows last byte
// R09 - Busy: output off, requests ignored
// R10 - Page write one to four bytes, row
// R11 - Master avoids row roll-over
// R12 - In-page counter advances per data byte
// R13 - No select ack while busy; polling
// R14 - Random read repeats same seven bits
// R15 - Reads ignore write-lock bits
// R16 - Random read: dummy write, restart, read
// R17 - Current read outputs byte, then increments
// R18 - Sequential read continues, wraps to zero
// R19 - Master nack ends read, standby
// R20 - Password and 64 lock bits gate writes
// R21 - Write time is a parameter, busy
`timescale 1ns/1ps
`include "link_map.svh"
module tag_slave_end
	import link_pkg::*;
#(
	parameter int unsigned WRITE_CYCLES = `WRITE_CYCLES,
	parameter int unsigned ADDR_W = `ADDR_WIDTH
) (
	input wire logic clock,
	input wire logic rstn,
	i2c_link_if.device link,
	input wire logic chip_enable_high_bit,
	input wire logic [`SECTOR_COUNT-1:0] write_lock,
	input wire logic password_ok,
	output logic busy
);
	localparam int unsigned SEC_W = $clog2(`SECTOR_COUNT);
	generate
		if (ADDR_W < SEC_W + 2 || ADDR_W > 16 || WRITE_CYCLES < 1) begin : g_bad
			$error("tag_slave_end: unsupported parameters");
		end
	endgenerate

	logic [7:0] mem [0:(1 << ADDR_W) - 1];
	slave_state_type st_q, st_d;
	logic [3:0] cnt_q, cnt_d;
	logic nine_q, nine_d, ten_q, ten_d, drive_q, drive_d, ack_q, ack_d;
	logic busy_q, busy_d, scl_p_q, sda_p_q;
	logic [7:0] shr_q, shr_d, tx_q, tx_d, ahi_q, ahi_d;
	logic [ADDR_W-1:0] addr_q, addr_d, next_q, next_d;
	logic [7:0] pbuf_q [0:`PAGE_BYTES-1];
	logic [7:0] pbuf_d [0:`PAGE_BYTES-1];
	logic [`PAGE_BYTES-1:0] mask_q, mask_d;
	logic [31:0] timer_q, timer_d;
	logic rise, fall, start_ev, stop_ev, commit;

	function automatic logic locked(input logic [ADDR_W-1:0] a);
		locked = write_lock[a[ADDR_W-1 -: SEC_W]] & ~password_ok;
	endfunction

	assign rise = link.scl & ~scl_p_q;
	assign fall = ~link.scl & scl_p_q;
	assign start_ev = link.scl & scl_p_q & sda_p_q & ~link.sda;
	assign stop_ev = link.scl & scl_p_q & ~sda_p_q & link.sda;
	assign commit = busy_q && timer_q == 32'h0;
	assign busy = busy_q;
	assign link.device_sda_o = 1'b0;
	assign link.device_sda_oe = drive_q;

	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		nine_d = nine_q;
		ten_d = ten_q;
		drive_d = drive_q;
		ack_d = ack_q;
		busy_d = busy_q;
		shr_d = shr_q;
		tx_d = tx_q;
		ahi_d = ahi_q;
		addr_d = addr_q;
		next_d = next_q;
		pbuf_d = pbuf_q;
		mask_d = mask_q;
		timer_d = timer_q;
		if (busy_q) begin
			drive_d = 1'b0; // R09
			timer_d = timer_q - 32'h1;
			if (commit) begin
				busy_d = 1'b0; // R13
				addr_d = next_q; // R08
			end
		end else if (start_ev) begin
			st_d = st_sel;
			cnt_d = 4'h0;
			nine_d = 1'b0;
			ten_d = 1'b0;
			drive_d = 1'b0;
		end else if (stop_ev) begin
			if (ten_q && st_q == st_wdata && mask_q != '0) begin
				busy_d = 1'b1; // R07
				timer_d = WRITE_CYCLES - 1; // R21
			end
			st_d = st_idle;
			ten_d = 1'b0;
			nine_d = 1'b0;
			drive_d = 1'b0;
		end else if (st_q != st_idle) begin
			if (rise) begin
				if (nine_q) begin
					if (st_q == st_rdata && link.sda) begin
						st_d = st_idle; // R19
					end
				end else if (cnt_q < 4'h8) begin
					shr_d = {shr_q[6:0], link.sda}; // R01
					cnt_d = cnt_q + 4'h1;
				end
			end else if (fall) begin
				ten_d = 1'b0; // R07
				if (nine_q) begin
					nine_d = 1'b0;
					drive_d = 1'b0;
					ten_d = st_q == st_wdata && ack_q;
					if (st_q == st_rdata) begin
						tx_d = mem[addr_q]; // R17 R15
						addr_d = addr_q + 1'b1; // R18
						drive_d = ~tx_d[7];
					end
				end else if (cnt_q == 4'h8) begin
					nine_d = 1'b1;
					cnt_d = 4'h0;
					ack_d = 1'b1;
					unique case (st_q)
						st_sel: begin
							if (shr_q[7:1] == {`TYPE_ID, chip_enable_high_bit, `CE_LOW_BITS}) begin
								st_d = shr_q[0] == `DIR_READ ? st_rdata : st_ahi; // R02 R03
							end else begin
								st_d = st_idle; // R03
								ack_d = 1'b0;
							end
						end
						st_ahi: begin
							ahi_d = shr_q; // R04 R05
						end
						st_alo: begin
							addr_d = ADDR_W'({ahi_q, shr_q}); // R04 R16
							mask_d = '0;
						end
						st_wdata: begin
							if (locked(addr_q)) begin
								ack_d = 1'b0; // R06 R20
							end else begin
								pbuf_d[addr_q[1:0]] = shr_q; // R10
								mask_d[addr_q[1:0]] = 1'b1;
								addr_d[1:0] = addr_q[1:0] + 2'h1; // R12
								next_d = addr_q + 1'b1;
							end
						end
						st_rdata: begin
							ack_d = 1'b0;
						end
						st_idle: begin
							ack_d = 1'b0;
						end
					endcase
					if (st_q == st_ahi) begin
						st_d = st_alo;
					end else if (st_q == st_alo) begin
						st_d = st_wdata;
					end
					drive_d = ack_d;
				end else if (st_q == st_rdata && cnt_q != 4'h0) begin
					tx_d = {tx_q[6:0], 1'b1};
					drive_d = ~tx_d[7];
				end
			end
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			st_q <= st_idle;
			cnt_q <= 4'h0;
			nine_q <= 1'b0;
			ten_q <= 1'b0;
			drive_q <= 1'b0;
			ack_q <= 1'b0;
			busy_q <= 1'b0;
			shr_q <= 8'h00;
			tx_q <= 8'hFF;
			ahi_q <= 8'h00;
			addr_q <= '0;
			next_q <= '0;
			mask_q <= '0;
			timer_q <= 32'h0;
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
			for (int i = 0; i < `PAGE_BYTES; i++) begin
				pbuf_q[i] <= 8'h00;
			end
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			nine_q <= nine_d;
			ten_q <= ten_d;
			drive_q <= drive_d;
			ack_q <= ack_d;
			busy_q <= busy_d;
			shr_q <= shr_d;
			tx_q <= tx_d;
			ahi_q <= ahi_d;
			addr_q <= addr_d;
			next_q <= next_d;
			mask_q <= mask_d;
			timer_q <= timer_d;
			scl_p_q <= link.scl;
			sda_p_q <= link.sda;
			pbuf_q <= pbuf_d;
		end
	end

	// Page commit at end of write time
	always_ff @(posedge clock) begin
		for (int i = 0; i < `PAGE_BYTES; i++) begin
			if (commit && mask_q[i]) begin
				mem[{addr_q[ADDR_W-1:2], 2'(i)}] <= pbuf_q[i]; // R10
			end
		end
	end
endmodule

// ==== hdl/bus_master_end.sv ====
`timescale 1ns/1ps
`include "link_map.svh"
module bus_master_end
	import link_pkg::*;
#(
	parameter int unsigned QUARTER = `QUARTER_CYCLES
) (
	input wire logic clock,
	input wire logic rstn,
	i2c_link_if.master link,
	input wire logic op_valid,
	output logic op_ready,
	input wire op_type op_code,
	input wire logic [7:0] op_data,
	input wire logic op_send_ack,
	output logic done,
	output logic [7:0] rx_data,
	output logic rx_ack
);
	generate
		if (QUARTER < 1 || QUARTER > 65535) begin : g_bad
			$error("bus_master_end: unsupported QUARTER");
		end
	endgenerate

	master_state_type st_q, st_d;
	logic [15:0] div_q, div_d;
	logic [1:0] ph_q, ph_d;
	logic [3:0] bit_q, bit_d;
	logic [8:0] sh_q, sh_d, rx_q, rx_d;
	logic scl_q, scl_d, sda_q, sda_d, done_q, done_d;
	logic tick;

	assign tick = div_q == 16'h0;
	assign op_ready = st_q == m_idle;
	assign done = done_q;
	assign rx_data = rx_q[8:1];
	assign rx_ack = ~rx_q[0];
	assign link.scl = scl_q;
	assign link.master_sda_o = 1'b0;
	assign link.master_sda_oe = ~sda_q;

	always_comb begin
		st_d = st_q;
		div_d = tick ? 16'(QUARTER - 1) : div_q - 16'h1;
		ph_d = ph_q;
		bit_d = bit_q;
		sh_d = sh_q;
		rx_d = rx_q;
		scl_d = scl_q;
		sda_d = sda_q;
		done_d = 1'b0;
		unique case (st_q)
			m_idle: begin
				if (op_valid) begin
					ph_d = 2'h0;
					bit_d = 4'h0;
					unique case (op_code)
						op_start: st_d = m_start;
						op_stop: st_d = m_stop;
						op_write: begin
							st_d = m_bits;
							sh_d = {op_data, 1'b1}; // R01 R05
						end
						op_read: begin
							st_d = m_bits;
							sh_d = {8'hFF, ~op_send_ack}; // R19
						end
					endcase
				end
			end
			m_start: begin
				if (tick) begin
					ph_d = ph_q + 2'h1;
					unique case (ph_q)
						2'h0: sda_d = 1'b1;
						2'h1: scl_d = 1'b1;
						2'h2: sda_d = 1'b0;
						2'h3: begin
							scl_d = 1'b0;
							st_d = m_idle;
							done_d = 1'b1;
						end
					endcase
				end
			end
			m_stop: begin
				if (tick) begin
					ph_d = ph_q + 2'h1;
					unique case (ph_q)
						2'h0: sda_d = 1'b0;
						2'h1: scl_d = 1'b1;
						2'h2: sda_d = 1'b1;
						2'h3: begin
							st_d = m_idle;
							done_d = 1'b1;
						end
					endcase
				end
			end
			m_bits: begin
				if (tick) begin
					ph_d = ph_q + 2'h1;
					unique case (ph_q)
						2'h0: sda_d = sh_q[8];
						2'h1: scl_d = 1'b1;
						2'h2: rx_d = {rx_q[7:0], link.sda};
						2'h3: begin
							scl_d = 1'b0;
							sh_d = {sh_q[7:0], 1'b1};
							bit_d = bit_q + 4'h1;
							if (bit_q == 4'h8) begin
								st_d = m_idle;
								done_d = 1'b1;
							end
						end
					endcase
				end
			end
		endcase
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			st_q <= m_idle;
			div_q <= 16'h0;
			ph_q <= 2'h0;
			bit_q <= 4'h0;
			sh_q <= 9'h1FF;
			rx_q <= 9'h1FF;
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			done_q <= 1'b0;
		end else begin
			st_q <= st_d;
			div_q <= div_d;
			ph_q <= ph_d;
			bit_q <= bit_d;
			sh_q <= sh_d;
			rx_q <= rx_d;
			scl_q <= scl_d;
			sda_q <= sda_d;
			done_q <= done_d;
		end
	end
endmodule

// ==== bench/link_props.sv ====
`timescale 1ns/1ps
module link_props (
	input wire logic clock,
	input wire logic rstn,
	input wire logic scl,
	input wire logic sda,
	input wire logic device_sda_oe,
	input wire logic busy
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rstn);
	AST_BUSY_QUIET: assert property (busy |-> !device_sda_oe)
		else $error("drive while busy");
	AST_OE_RISE: assert property ($rose(device_sda_oe) |-> !scl)
		else $error("oe rise");
	AST_OE_FALL: assert property ($fell(device_sda_oe) |-> !scl)
		else $error("oe fall");
	AST_OE_HOLD: assert property (scl && $past(scl) |-> $stable(device_sda_oe))
		else $error("oe hold");
	AST_BUSY_MIN: assert property ($rose(busy) |-> busy[*8])
		else $error("busy short");
	AST_BUSY_MAX: assert property ($rose(busy) |-> ##[1:300] !busy)
		else $error("busy long");
	AST_BUSY_STOP: assert property ($rose(busy) |-> scl && sda)
		else $error("busy start");
	AST_STOP_FREE: assert property (scl && $rose(sda) |-> !device_sda_oe)
		else $error("stop driven");
endmodule

// ==== bench/test_i2c_eeprom_slave_access.sv ====
`timescale 1ns/1ps
module test_i2c_eeprom_slave_access;
	import link_pkg::*;
	logic clock, rstn, op_valid, op_ready, op_send_ack, done, rx_ack, busy, ce, password_ok;
	op_type op_code;
	logic [7:0] op_data, rx_data, d0;
	logic [7:0] pg [5];
	logic [63:0] write_lock;
	integer seed, bad_count, checks, i;
	i2c_link_if link();
	bus_master_end #(.QUARTER(4)) u_bus_master_end (.clock(clock), .rstn(rstn), .link(link),
		.op_valid(op_valid), .op_ready(op_ready), .op_code(op_code), .op_data(op_data),
		.op_send_ack(op_send_ack), .done(done), .rx_data(rx_data), .rx_ack(rx_ack));
	tag_slave_end #(.WRITE_CYCLES(200)) u_tag_slave_end (.clock(clock), .rstn(rstn), .link(link),
		.chip_enable_high_bit(ce), .write_lock(write_lock), .password_ok(password_ok),
		.busy(busy));
	link_props u_link_props (.clock(clock), .rstn(rstn), .scl(link.scl), .sda(link.sda),
		.device_sda_oe(link.device_sda_oe), .busy(busy));
	task test_done;
		$display("Checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task op(input op_type c, input logic [7:0] d, input logic k);
		logic seen;
		seen = 1'h0;
		op_valid <= 1'h1;
		op_code <= c;
		op_data <= d;
		op_send_ack <= k;
		@(posedge clock);
		op_valid <= 1'h0;
		@(negedge clock);
		cmp("op ready", 8'h00, {7'h0, op_ready});
		repeat (1000) begin
			@(negedge clock);
			if (done === 1'h1) begin
				seen = 1'h1;
				break;
			end
		end
		if (seen !== 1'h1) begin
			bad_count++;
		end
		@(posedge clock);
	endtask
	task sel(input logic rw, input logic e);
		op(op_start, 8'h00, 1'h0);
		op(op_write, {4'hA, e, 2'h3, rw}, 1'h0);
	endtask
	task addr(input logic [15:0] a);
		sel(1'h0, 1'h1);
		cmp("select ack", 8'h01, {7'h0, rx_ack});
		op(op_write, a[15:8], 1'h0);
		cmp("addr hi ack", 8'h01, {7'h0, rx_ack});
		op(op_write, a[7:0], 1'h0);
		cmp("addr lo ack", 8'h01, {7'h0, rx_ack});
	endtask
	task wr(input logic [7:0] d, input logic e);
		op(op_write, d, 1'h0);
		cmp("data ack", {7'h0, e}, {7'h0, rx_ack});
	endtask
	task rd(input logic [7:0] e, input logic k);
		op(op_read, 8'h00, k);
		cmp("read data", e, rx_data);
	endtask
	task stop_busy(input logic e, input int n);
		op(op_stop, 8'h00, 1'h0);
		repeat (n) @(posedge clock);
		@(negedge clock);
		cmp("busy", {7'h0, e}, {7'h0, busy});
		repeat (400) begin
			@(negedge clock);
			if (busy === 1'h0) break;
		end
		if (busy !== 1'h0) begin
			bad_count++;
		end
		@(posedge clock);
	endtask
	initial begin
		clock = 1'h0;
		forever #4 clock = ~clock;
	end
	initial begin
		#(8 * 50000);
		bad_count++;
		test_done;
	end
	initial begin
		seed = 4;
		bad_count = 0;
		checks = 0;
		rstn = 1'h0;
		op_valid = 1'h0;
		op_code = op_start;
		op_data = 8'h00;
		op_send_ack = 1'h0;
		ce = 1'h1;
		password_ok = 1'h0;
		write_lock = 64'h0;
		d0 = $random(seed);
		for (i = 0; i < 5; i++) pg[i] = $random(seed);
		repeat (4) @(posedge clock);
		rstn <= 1'h1;
		@(posedge clock);
		addr(16'h0000);
		wr(d0, 1'h1);
		stop_busy(1'h1, 8);
		$display("test byte write ends");
		sel(1'h0, 1'h1);
		cmp("poll ack", 8'h01, {7'h0, rx_ack});
		stop_busy(1'h0, 8);
		sel(1'h0, 1'h0);
		cmp("mismatch ack", 8'h00, {7'h0, rx_ack});
		stop_busy(1'h0, 8);
		ce <= 1'h0;
		sel(1'h0, 1'h0);
		cmp("low enable ack", 8'h01, {7'h0, rx_ack});
		stop_busy(1'h0, 8);
		ce <= 1'h1;
		addr(16'h1FFC);
		for (i = 0; i < 4; i++) wr(pg[i], 1'h1);
		stop_busy(1'h1, 8);
		sel(1'h1, 1'h1);
		rd(d0, 1'h0);
		stop_busy(1'h0, 2);
		addr(16'h1FFC);
		sel(1'h1, 1'h1);
		for (i = 0; i < 4; i++) rd(pg[i], 1'h1);
		rd(d0, 1'h0);
		stop_busy(1'h0, 2);
		$display("test page and reads ends");
		write_lock <= 64'h8000000000000000;
		addr(16'h1FFD);
		wr(pg[4], 1'h0);
		stop_busy(1'h0, 8);
		addr(16'h1FFD);
		sel(1'h1, 1'h1);
		rd(pg[1], 1'h0);
		stop_busy(1'h0, 2);
		password_ok <= 1'h1;
		addr(16'h1FFD);
		wr(pg[4], 1'h1);
		stop_busy(1'h1, 8);
		addr(16'h1FFD);
		sel(1'h1, 1'h1);
		rd(pg[4], 1'h0);
		stop_busy(1'h0, 2);
		$display("test lock ends");
		test_done;
	end
endmodule
